// ===== rtl/spbc_baud_ctrl.sv
// serial port baud generator, upper control bits, transmit fifo and simple frame engine
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "spbc_regs.svh"

module spbc_baud_ctrl #(
  parameter int BG_W  = `SPBC_BG_W,
  parameter int FDV_W = `SPBC_FDV_W,
  parameter int DEPTH = `SPBC_TXF_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        rxdPin,
  output logic             txdPin,
  output logic             autobaudRefTick,
  output logic             txFifoFull
);
  localparam int DB = `SPBC_DATA_BITS;

  spbc_pkg::spbc_req_t  req;                      // bundled register request
  spbc_pkg::spbc_ctrl_t ctrl_ff, nxt_ctrl;        // control register
  logic [BG_W-1:0]      reload_ff, nxt_reload;    // baud_reload value
  logic [BG_W-1:0]      count_ff, nxt_count;      // baud_timer_count
  logic [FDV_W-1:0]     fdv_ff, nxt_fdv;          // frac_ratio_value
  logic [1:0]           presCnt_ff, nxt_presCnt;  // divide-by-2/3 counter
  logic [31:0]          rdata_ff, nxt_rdata;      // read data register
  logic                 abRef_ff, nxt_abRef;      // autobaud reference tick
  logic                 txFull_ff, nxt_txFull;    // registered fifo full
  logic                 rxS1_ff, rxS2_ff;         // receive pin synchroniser
  spbc_pkg::spbc_tx_t   txSt_ff, nxt_txSt;        // transmitter state
  logic [DB-1:0]        txDat_ff, nxt_txDat;      // word being sent
  logic [2:0]           txIdx_ff, nxt_txIdx;      // transmit bit index
  logic                 txd_ff, nxt_txd;          // serial output line
  spbc_pkg::spbc_rx_t   rxSt_ff, nxt_rxSt;        // receiver state
  logic [DB-1:0]        rxSh_ff, nxt_rxSh;        // receive shifter
  logic [2:0]           rxIdx_ff, nxt_rxIdx;      // receive bit index
  logic [DB-1:0]        rxBuf_ff, nxt_rxBuf;      // received word
  logic                 rxFull_ff, nxt_rxFull;    // received word unread
  logic                 fracTick;                 // fractional divider output
  logic                 presTick;                 // prescaled_baud_clock
  logic                 bitTick;                  // one per timer reload
  logic                 rxLine;                   // line seen by receiver
  logic                 rxDone;                   // frame finished this cycle
  logic                 fifoInReady, fifoOutValid, txPop;
  logic [DB-1:0]        fifoOutData;
  logic                 overrun_check_enable;

  assign req             = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign regRdata        = rdata_ff;
  assign txdPin          = txd_ff;
  assign autobaudRefTick = abRef_ff;
  assign txFifoFull      = txFull_ff;
  assign overrun_check_enable             = ctrl_ff.low[`SPBC_LOW_OEN];

  // fractional divider runs only when selected and running
  spbc_frac_div #(
    .W (FDV_W)
  ) u_frac (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (ctrl_ff.run && ctrl_ff.fde),
    .ratio   (fdv_ff),
    .tick    (fracTick)
  );

  // transmit words wait here until the frame engine takes them
  spbc_fifo #(
    .WIDTH (DB),
    .DEPTH (DEPTH)
  ) u_txf (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (req.wr && req.addr == `SPBC_ADDR_TXD),
    .inData   (req.wdata[DB-1:0]),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (txPop)
  );

  // prescaler and baud timer next values
  always_comb begin
    nxt_presCnt = '0;
    if (ctrl_ff.fde) begin
      presTick = fracTick;
    end else begin
      presTick    = ctrl_ff.run &&
                    (presCnt_ff == (ctrl_ff.prescale_select ? `SPBC_DIV3_LAST : `SPBC_DIV2_LAST));
      nxt_presCnt = (!ctrl_ff.run || presTick) ? 2'h0 : 2'(presCnt_ff + 2'h1);
    end
    bitTick = ctrl_ff.run && presTick && (count_ff == '0);
    if (!ctrl_ff.run || bitTick) begin
      nxt_count = reload_ff;
    end else if (presTick) begin
      nxt_count = BG_W'(count_ff - 1'b1);
    end else begin
      nxt_count = count_ff;
    end
    nxt_abRef  = fracTick;
    nxt_txFull = !fifoInReady;
  end

  // register prescaler and timer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      presCnt_ff <= '0;
      count_ff   <= `SPBC_RST_BG;
      abRef_ff   <= 1'b0;
      txFull_ff  <= 1'b0;
    end else begin
      presCnt_ff <= nxt_presCnt;
      count_ff   <= nxt_count;
      abRef_ff   <= nxt_abRef;
      txFull_ff  <= nxt_txFull;
    end
  end

  // receive pin synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxS1_ff <= 1'b1;
      rxS2_ff <= 1'b1;
    end else begin
      rxS1_ff <= rxdPin;
      rxS2_ff <= rxS1_ff;
    end
  end

  // transmitter next state: start, data lsb first, parity, stop
  always_comb begin
    nxt_txSt  = txSt_ff;
    nxt_txDat = txDat_ff;
    nxt_txIdx = txIdx_ff;
    nxt_txd   = txd_ff;
    txPop     = 1'b0;
    if (!ctrl_ff.run) begin
      nxt_txSt = spbc_pkg::TX_IDLE;
      nxt_txd  = 1'b1;
    end else if (bitTick) begin
      case (txSt_ff)
        spbc_pkg::TX_IDLE: begin
          // take a word when one waits
          if (fifoOutValid) begin
            txPop     = 1'b1;
            nxt_txDat = fifoOutData;
            nxt_txIdx = '0;
            nxt_txd   = 1'b0;
            nxt_txSt  = spbc_pkg::TX_START;
          end
        end
        spbc_pkg::TX_START: begin
          nxt_txd  = txDat_ff[0];
          nxt_txSt = spbc_pkg::TX_DATA;
        end
        spbc_pkg::TX_DATA: begin
          if (txIdx_ff == 3'(DB - 1)) begin
            nxt_txd  = (^txDat_ff) ^ ctrl_ff.odd;
            nxt_txSt = spbc_pkg::TX_PAR;
          end else begin
            nxt_txIdx = 3'(txIdx_ff + 3'h1);
            nxt_txd   = txDat_ff[3'(txIdx_ff + 3'h1)];
          end
        end
        spbc_pkg::TX_PAR: begin
          nxt_txd  = 1'b1;
          nxt_txSt = spbc_pkg::TX_STOP;
        end
        default: begin
          nxt_txSt = spbc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // register transmitter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txSt_ff  <= spbc_pkg::TX_IDLE;
      txDat_ff <= '0;
      txIdx_ff <= '0;
      txd_ff   <= 1'b1;
    end else begin
      txSt_ff  <= nxt_txSt;
      txDat_ff <= nxt_txDat;
      txIdx_ff <= nxt_txIdx;
      txd_ff   <= nxt_txd;
    end
  end

  // receiver next state, sampling once per bit tick
  always_comb begin
    rxLine    = ctrl_ff.loop ? txd_ff : rxS2_ff;
    nxt_rxSt  = rxSt_ff;
    nxt_rxSh  = rxSh_ff;
    nxt_rxIdx = rxIdx_ff;
    rxDone    = 1'b0;
    if (!ctrl_ff.run) begin
      nxt_rxSt = spbc_pkg::RX_IDLE;
    end else if (bitTick) begin
      case (rxSt_ff)
        spbc_pkg::RX_IDLE: begin
          // low line is a start bit
          if (!rxLine) begin
            nxt_rxIdx = '0;
            nxt_rxSt  = spbc_pkg::RX_DATA;
          end
        end
        spbc_pkg::RX_DATA: begin
          nxt_rxSh  = {rxLine, rxSh_ff[DB-1:1]};
          nxt_rxIdx = 3'(rxIdx_ff + 3'h1);
          if (rxIdx_ff == 3'(DB - 1)) begin
            nxt_rxSt = spbc_pkg::RX_PAR;
          end
        end
        spbc_pkg::RX_PAR: begin
          nxt_rxSt = spbc_pkg::RX_STOP;
        end
        default: begin
          rxDone   = 1'b1;
          nxt_rxSt = spbc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // register receiver
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxSt_ff  <= spbc_pkg::RX_IDLE;
      rxSh_ff  <= '0;
      rxIdx_ff <= '0;
    end else begin
      rxSt_ff  <= nxt_rxSt;
      rxSh_ff  <= nxt_rxSh;
      rxIdx_ff <= nxt_rxIdx;
    end
  end

  // register writes, read effects and hardware flag set
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_reload = reload_ff;
    nxt_fdv    = fdv_ff;
    nxt_rxBuf  = rxBuf_ff;
    nxt_rxFull = rxFull_ff;
    nxt_rdata  = '0;
    // address decode for writes
    if (req.wr && req.addr == `SPBC_ADDR_CON) begin
      nxt_ctrl = req.wdata[15:0];
    end else if (req.wr && req.addr == `SPBC_ADDR_BG) begin
      nxt_reload = req.wdata[BG_W-1:0];
    end else if (req.wr && req.addr == `SPBC_ADDR_FDV) begin
      nxt_fdv = req.wdata[FDV_W-1:0];
    end
    // reading the received word frees it
    if (req.rd && req.addr == `SPBC_ADDR_RXD) begin
      nxt_rxFull = 1'b0;
    end
    // new word wins over a read
    if (rxDone) begin
      nxt_rxBuf  = rxSh_ff;
      nxt_rxFull = 1'b1;
      // overrun sets flag, wins over clear
      if (rxFull_ff && overrun_check_enable) begin
        nxt_ctrl.oe = 1'b1;
      end
    end
    // address decode for reads, upper bits zero
    if (!req.rd) begin
      nxt_rdata = '0;
    end else if (req.addr == `SPBC_ADDR_CON) begin
      nxt_rdata = 32'(ctrl_ff);
    end else if (req.addr == `SPBC_ADDR_BG) begin
      nxt_rdata = 32'(count_ff);
    end else if (req.addr == `SPBC_ADDR_FDV) begin
      nxt_rdata = 32'(fdv_ff);
    end else if (req.addr == `SPBC_ADDR_RXD) begin
      nxt_rdata = 32'(rxBuf_ff);
    end else if (req.addr == `SPBC_ADDR_STAT) begin
      nxt_rdata = 32'({fifoOutValid, txFull_ff, rxFull_ff});
    end
  end

  // register file
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_ff   <= `SPBC_RST_CON;
      reload_ff <= `SPBC_RST_BG;
      fdv_ff    <= `SPBC_RST_FDV;
      rxBuf_ff  <= '0;
      rxFull_ff <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      reload_ff <= nxt_reload;
      fdv_ff    <= nxt_fdv;
      rxBuf_ff  <= nxt_rxBuf;
      rxFull_ff <= nxt_rxFull;
      rdata_ff  <= nxt_rdata;
    end
  end

  // checks on the guarded behaviour
  property p_overrun;
    @(posedge clk) disable iff (!reset_n) (rxDone && rxFull_ff && overrun_check_enable) |=> ctrl_ff.oe;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");
  property p_frac_sel;
    @(posedge clk) disable iff (!reset_n) (ctrl_ff.run && ctrl_ff.fde) |-> presTick == fracTick;
  endproperty
  a_frac_sel: assert property (p_frac_sel) else $error("prescaler not from divider");
  property p_parity;
    @(posedge clk) disable iff (!reset_n)
      (txSt_ff == spbc_pkg::TX_PAR) |-> txd_ff == ((^txDat_ff) ^ ctrl_ff.odd);
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit polarity wrong");
  property p_div3;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_ff.run && !ctrl_ff.fde && ctrl_ff.prescale_select && presTick && $stable(ctrl_ff))
        |=> !presTick [*2];
  endproperty
  a_div3: assert property (p_div3) else $error("divide-by-3 spacing wrong");
  property p_run_idle;
    @(posedge clk) disable iff (!reset_n)
      !ctrl_ff.run |=> txd_ff && !bitTick && rxSt_ff == spbc_pkg::RX_IDLE;
  endproperty
  a_run_idle: assert property (p_run_idle) else $error("interface active while stopped");
  property p_bg_read;
    @(posedge clk) disable iff (!reset_n)
      (req.rd && req.addr == `SPBC_ADDR_BG) |=> rdata_ff == 32'($past(count_ff));
  endproperty
  a_bg_read: assert property (p_bg_read) else $error("timer read wrong");
  property p_abd_ref;
    @(posedge clk) disable iff (!reset_n) fracTick |=> autobaudRefTick;
  endproperty
  a_abd_ref: assert property (p_abd_ref) else $error("autobaud reference missing");
  property p_con_upper;
    @(posedge clk) disable iff (!reset_n)
      (req.rd && req.addr == `SPBC_ADDR_CON) |=> rdata_ff[31:16] == 16'h0000;
  endproperty
  a_con_upper: assert property (p_con_upper) else $error("upper control bits not zero");
  property p_reload;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_ff.run && presTick && count_ff == '0) |=> count_ff == $past(reload_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload");

endmodule : spbc_baud_ctrl

// ===== rtl/spbc_fifo.sv
// transmit fifo with registered read data
`timescale 1ns/1ps
`include "spbc_regs.svh"

module spbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SPBC_TXF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];       // storage array
  logic [AW-1:0]    wPtr_ff, nxt_wPtr;  // write pointer
  logic [AW-1:0]    rPtr_ff, nxt_rPtr;  // read pointer
  logic [CW-1:0]    cnt_ff, nxt_cnt;    // words held in the array
  logic             oVal_ff, nxt_oVal;  // output stage holds a word
  logic [WIDTH-1:0] oDat_ff, nxt_oDat;  // output stage word
  logic             push, pull;

  // the output stage counts toward the depth, so at most DEPTH words are held in all
  assign inReady  = (((CW+1)'(cnt_ff) + (CW+1)'(oVal_ff)) < (CW+1)'(DEPTH));
  assign outValid = oVal_ff;
  assign outData  = oDat_ff;

  // next pointer, count and output stage
  always_comb begin
    push     = inValid && inReady;
    pull     = (cnt_ff != '0) && (!oVal_ff || outReady);
    nxt_wPtr = push ? AW'(wPtr_ff + 1'b1) : wPtr_ff;
    nxt_rPtr = pull ? AW'(rPtr_ff + 1'b1) : rPtr_ff;
    nxt_cnt  = CW'(cnt_ff + CW'(push) - CW'(pull));
    nxt_oDat = pull ? mem[rPtr_ff] : oDat_ff;
    // stage refills on a pull, empties on a take
    if (pull) begin
      nxt_oVal = 1'b1;
    end else if (outReady) begin
      nxt_oVal = 1'b0;
    end else begin
      nxt_oVal = oVal_ff;
    end
  end

  // register state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wPtr_ff <= '0;
      rPtr_ff <= '0;
      cnt_ff  <= '0;
      oVal_ff <= 1'b0;
      oDat_ff <= '0;
    end else begin
      wPtr_ff <= nxt_wPtr;
      rPtr_ff <= nxt_rPtr;
      cnt_ff  <= nxt_cnt;
      oVal_ff <= nxt_oVal;
      oDat_ff <= nxt_oDat;
    end
  end

  // array write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wPtr_ff] <= inData;
    end
  end

endmodule : spbc_fifo

// ===== rtl/spbc_frac_div.sv
// fractional divider: ticks at ratio/512 of the clock, every clock with ratio zero
`timescale 1ns/1ps
`include "spbc_regs.svh"

module spbc_frac_div #(
  parameter int W = `SPBC_FDV_W
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         enable,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);
  logic [W-1:0] acc_ff, nxt_acc;    // phase accumulator
  logic         tick_ff, nxt_tick;  // output tick
  logic [W:0]   sum;

  assign tick = tick_ff;

  // accumulate ratio, carry out gives the tick
  always_comb begin
    sum      = {1'b0, acc_ff} + {1'b0, ratio};
    nxt_acc  = enable ? sum[W-1:0] : '0;
    nxt_tick = enable && ((ratio == '0) || sum[W]);
  end

  // register accumulator and tick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  property p_frac_zero;
    @(posedge clk) disable iff (!reset_n)
      (enable && ratio == '0) |=> tick;
  endproperty
  a_frac_zero: assert property (p_frac_zero) else $error("zero ratio did not pass clock");

endmodule : spbc_frac_div

// ===== shared/spbc_pkg.sv
// types shared by the serial port baud block
package spbc_pkg;

  // control register, bit 15 down to bit 0
  typedef struct packed {
    logic       run;      // baud generator run control
    logic       loop;     // loopback_enable
    logic       prescale_select;      // prescale_select
    logic       odd;      // parity polarity
    logic       fde;      // frac_divider_enable
    logic       oe;       // overrun error flag
    logic [9:0] low;      // lower control bits, overrun_check_enable among them
  } spbc_ctrl_t;

  // plain register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spbc_req_t;

  // transmitter states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} spbc_tx_t;

  // receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} spbc_rx_t;

endpackage : spbc_pkg

// ===== shared/spbc_regs.svh
// register offsets, field positions, reset values and counts of the serial port baud block
`ifndef SPBC_REGS_SVH
`define SPBC_REGS_SVH

// register addresses on the plain register port
`define SPBC_ADDR_BG     16'hFEB4
`define SPBC_ADDR_FDV    16'hFEB6
`define SPBC_ADDR_CON    16'hFEB8
`define SPBC_ADDR_TXD    16'hFEBA
`define SPBC_ADDR_RXD    16'hFEBC
`define SPBC_ADDR_STAT   16'hFEBE

// reset values
`define SPBC_RST_CON     16'h0000
`define SPBC_RST_BG      13'h0000
`define SPBC_RST_FDV     9'h000

// field widths and positions
`define SPBC_BG_W        13
`define SPBC_FDV_W       9
`define SPBC_LOW_OEN     7

// prescaler last counts for divide-by-2 and divide-by-3
`define SPBC_DIV2_LAST   2'h1
`define SPBC_DIV3_LAST   2'h2

// frame shape and transmit buffer depth
`define SPBC_DATA_BITS   8
`define SPBC_TXF_DEPTH   16

`endif

// ===== verification/spbc_remote.sv
// remote serial device model: frame drive on receive line, frame capture from transmit line
`timescale 1ns/1ps

module spbc_remote (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  // line rests idle high until send drives a frame toward the block
  initial rxd = 1'b1;

  // capture one frame: wait for the start edge, then sample each bit mid-way
  task automatic capture(input int per, output logic [10:0] frm, output bit ok);
    int n;
    n   = 0;
    frm = '0;
    // sampled on the falling edge, where the line has settled
    while (txd !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    ok = (n < 4000);
    // half a bit into the start bit
    repeat (per / 2) @(negedge clk);
    // start, 8 data, parity, stop; stop sampled mid-bit so the next start is seen
    for (int i = 0; i < 11; i++) begin
      frm[i] = txd;
      if (i < 10) repeat (per) @(negedge clk);
    end
  endtask : capture

  // drive one frame toward the block, bit 0 first, each bit per cycles long
  task automatic send(input int per, input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (per - 1) @(posedge clk);
    end
  endtask : send
endmodule : spbc_remote

// ===== verification/tb_spbc_baud_ctrl.sv
// self-checking testbench of the serial port baud block
`timescale 1ns/1ps
`include "spbc_regs.svh"

module tb_spbc_baud_ctrl;
  logic        clk;              // 25 MHz clock
  logic        reset_n;          // synchronous reset
  logic [15:0] regAddr;          // register port
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        rxdPin;           // from remote model
  logic        txdPin;           // to remote model
  logic        autobaudRefTick;  // divider reference tick
  logic        txFifoFull;       // fifo full flag
  int          n_errors;         // mismatch count
  int          n_checks;         // comparison count
  logic [31:0] rv;               // last read value
  logic [10:0] frm;              // captured frame
  bit          ok;               // capture success
  int          cnt;              // event counter

  spbc_baud_ctrl DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxdPin(rxdPin), .txdPin(txdPin),
    .autobaudRefTick(autobaudRefTick), .txFifoFull(txFifoFull));
  spbc_remote remote (.clk(clk), .txd(txdPin), .rxd(rxdPin));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict and end of run
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // compare seen against expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // give up on a wait that ran out
  task automatic need(input bit good);
    if (!good) begin
      n_errors++;
      end_of_test();
    end
  endtask : need

  // one-cycle register write
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask : rd

  // count cycles where the transmit line leaves idle
  task automatic low_cycles(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      if (txdPin !== 1'b1) cnt++;
    end
  endtask : low_cycles

  // reset values, unmapped read
  task automatic t_reset();
    check("txd idle", txdPin, 1);
    check("fifo full", txFifoFull, 0);
    rd(`SPBC_ADDR_BG);
    check("reload rst", rv, 0);
    rd(`SPBC_ADDR_FDV);
    check("ratio rst", rv, 0);
    rd(`SPBC_ADDR_CON);
    check("ctrl rst", rv, 0);
    wr(16'hFE00, 32'hFFFFFFFF);
    rd(16'hFE00);
    check("unmapped", rv, 0);
  endtask : t_reset

  // upper bits dropped on write and read as zero
  task automatic t_widths();
    wr(`SPBC_ADDR_BG, 32'hFFFFFFFF);
    rd(`SPBC_ADDR_BG);
    check("reload w", rv, 32'h00001FFF);
    wr(`SPBC_ADDR_FDV, 32'hFFFFFFFF);
    rd(`SPBC_ADDR_FDV);
    check("ratio w", rv, 32'h000001FF);
    wr(`SPBC_ADDR_CON, 32'hFFFF7BF8);
    rd(`SPBC_ADDR_CON);
    check("ctrl w", rv, 32'h00007BF8);
    wr(`SPBC_ADDR_CON, 0);
  endtask : t_widths

  // one frame at a given prescaler setting, held back until run is set
  task automatic t_frame(input logic [31:0] ctl, input logic [31:0] n, input int per,
                         input logic [7:0] b);
    wr(`SPBC_ADDR_BG, 3);
    wr(`SPBC_ADDR_FDV, n);
    wr(`SPBC_ADDR_CON, ctl);
    wr(`SPBC_ADDR_TXD, {24'h0, b});
    low_cycles(60);
    check("stopped idle", cnt, 0);
    wr(`SPBC_ADDR_CON, ctl | 32'h8000);
    remote.capture(per, frm, ok);
    need(ok);
    check("frame", frm, {1'b1, ^b ^ ctl[12], b, 1'b0});
    // a running timer must show counts below the reload value
    cnt = 0;
    repeat (4) begin
      rd(`SPBC_ADDR_BG);
      check("count range", (rv <= 32'h3), 1);
      if (rv < 32'h3) cnt++;
    end
    check("live count", (cnt > 0), 1);
    wr(`SPBC_ADDR_CON, 0);
  endtask : t_frame

  // a frame from the remote device arrives on the receive pin
  task automatic t_pin_rx();
    wr(`SPBC_ADDR_BG, 3);
    wr(`SPBC_ADDR_CON, 32'h8001);
    rd(`SPBC_ADDR_RXD);
    remote.send(8, {2'b11, 8'hC3, 1'b0});
    rv = 0;
    for (cnt = 0; cnt < 100 && rv[0] !== 1'b1; cnt++) rd(`SPBC_ADDR_STAT);
    need(cnt < 100);
    rd(`SPBC_ADDR_RXD);
    check("pin data", rv[7:0], 8'hC3);
    wr(`SPBC_ADDR_CON, 0);
  endtask : t_pin_rx

  // fifo filled while stopped, refused when full, drained in order
  task automatic t_fifo();
    wr(`SPBC_ADDR_BG, 3);
    wr(`SPBC_ADDR_FDV, 0);
    wr(`SPBC_ADDR_CON, 32'h0801);
    for (int i = 0; i < 17; i++) wr(`SPBC_ADDR_TXD, 32'h10 + i);
    check("fifo full", txFifoFull, 1);
    wr(`SPBC_ADDR_CON, 32'h8801);
    for (int i = 0; i < 16; i++) begin
      remote.capture(4, frm, ok);
      need(ok);
      check("fifo order", frm[8:1], 8'h10 + i);
    end
    low_cycles(100);
    check("dropped word", cnt, 0);
    check("fifo drained", txFifoFull, 0);
    wr(`SPBC_ADDR_CON, 0);
  endtask : t_fifo

  // loopback receive, then overrun sets a sticky flag cleared by software
  task automatic t_loop();
    wr(`SPBC_ADDR_BG, 3);
    wr(`SPBC_ADDR_CON, 32'hC081);
    wr(`SPBC_ADDR_TXD, 32'h3C);
    rv = 0;
    for (cnt = 0; cnt < 500 && rv[0] !== 1'b1; cnt++) rd(`SPBC_ADDR_STAT);
    need(cnt < 500);
    rd(`SPBC_ADDR_RXD);
    check("loop data", rv[7:0], 8'h3C);
    wr(`SPBC_ADDR_TXD, 32'h11);
    wr(`SPBC_ADDR_TXD, 32'h22);
    repeat (400) @(posedge clk);
    rd(`SPBC_ADDR_CON);
    check("overrun set", rv[10], 1);
    repeat (50) @(posedge clk);
    rd(`SPBC_ADDR_CON);
    check("overrun held", rv[10], 1);
    wr(`SPBC_ADDR_CON, 32'h4081);
    rd(`SPBC_ADDR_CON);
    check("overrun clear", rv, 32'h4081);
    wr(`SPBC_ADDR_CON, 0);
  endtask : t_loop

  // reference tick rate follows n/512, every clock with n zero, none when stopped
  task automatic t_autobaud(input logic [31:0] n, input int lo, input int hi);
    wr(`SPBC_ADDR_FDV, n);
    wr(`SPBC_ADDR_CON, 32'h8801);
    repeat (16) @(posedge clk);
    cnt = 0;
    repeat (1024) begin
      @(posedge clk);
      if (autobaudRefTick === 1'b1) cnt++;
    end
    check("ref rate", (cnt >= lo && cnt <= hi), 1);
    wr(`SPBC_ADDR_CON, 32'h0801);
    repeat (4) @(posedge clk);
    cnt = 0;
    repeat (100) begin
      @(posedge clk);
      if (autobaudRefTick !== 1'b0) cnt++;
    end
    check("ref stopped", cnt, 0);
  endtask : t_autobaud

  // main sequence
  initial begin
    reset_n  = 1'b0;
    regAddr  = '0;
    regWdata = '0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_widths();
    t_frame(32'h0001, 0, 8, 8'hA5);
    t_frame(32'h3001, 0, 12, 8'h5A);
    t_frame(32'h2801, 256, 8, 8'h81);
    // ratio zero passes the clock through
    t_frame(32'h1801, 0, 4, 8'hFF);
    t_fifo();
    t_loop();
    t_pin_rx();
    t_autobaud(128, 255, 257);
    t_autobaud(0, 1023, 1024);
    end_of_test();
  end
endmodule : tb_spbc_baud_ctrl
